// file: include/rcs_pkg.sv
/*
  Package of the receiver control sequencer: packet layout, setting indices,
  reset values, the state encoding and the step time unit.
  Assumes a 125 MHz system clock.
*/
package rcs_pkg;

  // ==========================================================
  // Packet layout
  localparam int PKT_ID_MSB = 31;
  localparam int PKT_ID_LSB = 24;
  localparam int PKT_ENABLE_BIT = 23;
  localparam int PKT_LBC_BIT = 19;
  localparam int PKT_B1_MSB = 15;
  localparam int PKT_B1_LSB = 8;
  localparam int PKT_B0_MSB = 7;
  localparam int PKT_B0_LSB = 0;

  // ==========================================================
  // Packet identifiers
  localparam logic [7:0] ID_LINE_OVERRIDE = 8'h0F;
  localparam logic [7:0] ID_SETTING_FIRST = 8'h10;
  localparam logic [7:0] ID_SETTING_LAST = 8'h1B;
  localparam logic [7:0] ID_SHUT_FIRST = 8'h1A;

  // ==========================================================
  // Setting indices (identifier minus the first setting identifier)
  localparam int NUM_SETTINGS = 12;
  localparam logic [3:0] IDX_OFF = 4'h0;
  localparam logic [3:0] IDX_WARM_FIRST = 4'h1;
  localparam logic [3:0] IDX_WARM_LAST = 4'h5;
  localparam logic [3:0] IDX_SYNC = 4'h6;
  localparam logic [3:0] IDX_SHUT_FIRST = 4'hA;
  localparam logic [3:0] IDX_SHUT_LAST = 4'hB;

  // ==========================================================
  // Step time field masks
  localparam logic [7:0] STEP_MASK_OFF = 8'hFF;
  localparam logic [7:0] STEP_MASK_ON = 8'h7F;
  localparam logic [7:0] STEP_MASK_SHUT = 8'h3F;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_STEP_TIME = 8'h01;
  localparam logic [7:0] RST_PATTERN = 8'h00;
  localparam logic [7:0] RST_FORCE = 8'h00;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int STEP_UNIT_US = 625;
  localparam int STEP_UNIT_CYCLES = STEP_UNIT_US * 1000 / CLK_PERIOD_NS;

  // ==========================================================
  // Types
  typedef struct packed {
    logic stepEnable;
    logic lowBatteryCheck;
    logic [7:0] linePattern;
    logic [7:0] stepTime;
  } rcs_setting_t;

  typedef struct packed {
    logic [7:0] lineForceBits;
    logic [7:0] forcedValues;
  } rcs_override_t;

  localparam rcs_setting_t RST_SETTING = '{1'b0, 1'b0, RST_PATTERN, RST_STEP_TIME};

  typedef enum logic [2:0] {
    RCS_IDLE = 3'h0,
    RCS_OFF = 3'h1,
    RCS_WARM = 3'h3,
    RCS_SYNC = 3'h2,
    RCS_SHUT = 3'h6
  } rcs_state_t;

endpackage

// file: verilog/rcs_step_timer.sv
/*
  Step timer: counts a number of 625 us units after a start pulse and
  pulses done once. Assumes start is a one-cycle pulse; a new start restarts.
*/
`timescale 1ns/1ps

module rcs_step_timer import rcs_pkg::*; #(
  parameter int UNIT_CYCLES = STEP_UNIT_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic [7:0] units,
  output logic done
);

  // ==========================================================
  // Counters
  logic [19:0] tickReg;
  logic [7:0] unitReg;
  logic runReg;
  logic unitEnd;
  logic [7:0] startUnits;

  // A zero code would mean no wait; hold at least one unit
  assign startUnits = (units == 8'h00) ? 8'h01 : units;
  assign unitEnd = runReg && (tickReg == 20'(UNIT_CYCLES - 1));
  assign done = unitEnd && (unitReg == 8'h01);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tickReg <= 20'h00000;
      unitReg <= 8'h00;
      runReg <= 1'b0;
    end else if (start) begin
      tickReg <= 20'h00000;
      unitReg <= startUnits;
      runReg <= 1'b1;
    end else if (unitEnd) begin
      tickReg <= 20'h00000;
      unitReg <= unitReg - 8'h01;
      runReg <= (unitReg != 8'h01);
    end else if (runReg) begin
      tickReg <= tickReg + 20'h00001;
    end
  end

endmodule

// file: verilog/rcs_sequencer.sv
/*
  Receiver control sequencer: takes configuration packets, stores twelve
  receiver settings and a line override, and steps the eight receiver
  control lines through off, warm-up, sync and shutdown.
  Assumes packets arrive as whole 32-bit words with a one-cycle strobe,
  byte 3 in the top bits, and that all inputs are synchronous to clk.
*/
`timescale 1ns/1ps

module rcs_sequencer import rcs_pkg::*; #(
  parameter int UNIT_CYCLES = STEP_UNIT_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic pktValid,
  input wire logic [31:0] pktData,
  input wire logic receiverOn,
  input wire logic lowBatteryInput,
  input wire logic externalSymbolInHi,
  input wire logic externalSymbolInLo,
  output logic [7:0] receiverControlLines,
  output logic [7:0] receiverControlOeN,
  output logic symbolsValid,
  output logic symbolHi,
  output logic symbolLo,
  output logic lowBatteryLatched,
  output logic lowBatterySampled,
  output rcs_state_t seqState
);

  // ==========================================================
  // Packet decode
  logic [7:0] pktId;
  logic [3:0] pktIdx;
  logic isOverride;
  logic isSetting;
  logic [7:0] stepMask;
  logic pktEnable;
  rcs_setting_t pktSetting;
  rcs_override_t pktOverride;

  assign pktId = pktData[PKT_ID_MSB:PKT_ID_LSB];
  assign pktIdx = 4'(pktId - ID_SETTING_FIRST);
  assign isOverride = pktValid && (pktId == ID_LINE_OVERRIDE);
  assign isSetting = pktValid && (pktId >= ID_SETTING_FIRST) && (pktId <= ID_SETTING_LAST);
  assign stepMask = (pktIdx == IDX_OFF) ? STEP_MASK_OFF :
                    (pktId >= ID_SHUT_FIRST) ? STEP_MASK_SHUT : STEP_MASK_ON;
  // Only warm-up and shutdown packets carry an enable bit
  assign pktEnable = pktData[PKT_ENABLE_BIT] &&
                     (((pktIdx >= IDX_WARM_FIRST) && (pktIdx <= IDX_WARM_LAST)) ||
                      (pktId >= ID_SHUT_FIRST));
  assign pktSetting = '{pktEnable, pktData[PKT_LBC_BIT],
                        pktData[PKT_B1_MSB:PKT_B1_LSB],
                        pktData[PKT_B0_MSB:PKT_B0_LSB] & stepMask};
  assign pktOverride = '{pktData[PKT_B1_MSB:PKT_B1_LSB], pktData[PKT_B0_MSB:PKT_B0_LSB]};

  // ==========================================================
  // Setting store
  // Writes while running are accepted; keeping them out of a live sequence is the host's job.
  rcs_setting_t settingReg [NUM_SETTINGS];
  rcs_override_t overrideReg;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SETTINGS; gi++) begin : gSetting
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          settingReg[gi] <= RST_SETTING;
        end else if (isSetting && (pktIdx == 4'(gi))) begin
          settingReg[gi] <= pktSetting;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      overrideReg <= '{RST_FORCE, RST_PATTERN};
    end else if (isOverride) begin
      overrideReg <= pktOverride;
    end
  end

  // ==========================================================
  // Sequencer state
  rcs_state_t state_reg;
  rcs_state_t state_next;
  logic [3:0] idx_reg;
  logic [3:0] idx_next;
  logic timerStart;
  logic timerDone;
  logic settled_reg;
  logic leaving;
  rcs_setting_t cur;
  rcs_setting_t nextWarm;
  rcs_setting_t shutFirst;
  rcs_setting_t shutLast;
  logic shutdownReq;

  assign cur = settingReg[idx_reg];
  assign nextWarm = settingReg[4'(idx_reg + 4'h1)];
  assign shutFirst = settingReg[IDX_SHUT_FIRST];
  assign shutLast = settingReg[IDX_SHUT_LAST];
  assign shutdownReq = !receiverOn && (state_reg != RCS_IDLE) && (state_reg != RCS_SHUT);

  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    if (shutdownReq) begin
      if (shutFirst.stepEnable) begin
        state_next = RCS_SHUT;
        idx_next = IDX_SHUT_FIRST;
      end else begin
        state_next = RCS_IDLE;
        idx_next = IDX_OFF;
      end
    end else begin
      case (state_reg)
        RCS_IDLE: begin
          if (receiverOn) begin
            state_next = RCS_OFF;
            idx_next = IDX_OFF;
          end
        end
        RCS_OFF: begin
          if (timerDone) begin
            if (settingReg[IDX_WARM_FIRST].stepEnable) begin
              state_next = RCS_WARM;
              idx_next = IDX_WARM_FIRST;
            end else begin
              state_next = RCS_SYNC;
              idx_next = IDX_SYNC;
            end
          end
        end
        RCS_WARM: begin
          if (timerDone) begin
            if ((idx_reg != IDX_WARM_LAST) && nextWarm.stepEnable) begin
              idx_next = 4'(idx_reg + 4'h1);
            end else begin
              state_next = RCS_SYNC;
              idx_next = IDX_SYNC;
            end
          end
        end
        RCS_SHUT: begin
          if (timerDone) begin
            if ((idx_reg == IDX_SHUT_FIRST) && shutLast.stepEnable) begin
              idx_next = IDX_SHUT_LAST;
            end else begin
              state_next = RCS_IDLE;
              idx_next = IDX_OFF;
            end
          end
        end
        default: begin
          state_next = state_reg;
          idx_next = idx_reg;
        end
      endcase
    end
  end

  // Timer restarts on every change of state or setting except a return to idle
  assign timerStart = (state_next != RCS_IDLE) && ((state_next != state_reg) || (idx_next != idx_reg));
  assign leaving = (state_next != state_reg) || (idx_next != idx_reg);

  rcs_step_timer #(
    .UNIT_CYCLES(UNIT_CYCLES)
  ) uTimer (
    .clk(clk),
    .nrst(nrst),
    .start(timerStart),
    .units(settingReg[idx_next].stepTime),
    .done(timerDone)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= RCS_IDLE;
      idx_reg <= IDX_OFF;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
    end
  end

  // Sync wait over: symbol inputs count as valid until the state is left
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      settled_reg <= 1'b0;
    end else if (state_next != RCS_SYNC) begin
      settled_reg <= 1'b0;
    end else if ((state_reg == RCS_SYNC) && timerDone) begin
      settled_reg <= 1'b1;
    end
  end

  // ==========================================================
  // Low battery sampling
  // Idle is not a timed state, so leaving it takes no sample
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lowBatteryLatched <= 1'b0;
      lowBatterySampled <= 1'b0;
    end else begin
      lowBatterySampled <= leaving && (state_reg != RCS_IDLE) && cur.lowBatteryCheck;
      if (leaving && (state_reg != RCS_IDLE) && cur.lowBatteryCheck) begin
        lowBatteryLatched <= lowBatteryInput;
      end
    end
  end

  // ==========================================================
  // Control line drive
  logic [7:0] linePattern;
  logic [7:0] lineNext;

  // While idle the receiver sits at the off pattern
  assign linePattern = settingReg[idx_reg].linePattern;
  assign lineNext = (overrideReg.lineForceBits & overrideReg.forcedValues) |
                    (~overrideReg.lineForceBits & linePattern);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      receiverControlLines <= 8'h00;
      receiverControlOeN <= 8'hFF;
      symbolsValid <= 1'b0;
      symbolHi <= 1'b0;
      symbolLo <= 1'b0;
    end else begin
      receiverControlLines <= lineNext;
      receiverControlOeN <= 8'h00;
      symbolsValid <= settled_reg;
      symbolHi <= settled_reg && externalSymbolInHi;
      symbolLo <= settled_reg && externalSymbolInLo;
    end
  end

  assign seqState = state_reg;

endmodule

// file: tb/rcs_sequencer_chk.sv
/*
  Port checker of the receiver control sequencer, bound to its top module.
  Assumes one clock domain and a short step unit handed down from the design.
*/
`timescale 1ns/1ps

module rcs_sequencer_chk import rcs_pkg::*; #(
  parameter int UNIT_CYCLES = STEP_UNIT_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic pktValid,
  input wire logic [31:0] pktData,
  input wire logic receiverOn,
  input wire logic lowBatteryInput,
  input wire logic externalSymbolInHi,
  input wire logic externalSymbolInLo,
  input wire logic [7:0] receiverControlLines,
  input wire logic [7:0] receiverControlOeN,
  input wire logic symbolsValid,
  input wire logic symbolHi,
  input wire logic symbolLo,
  input wire logic lowBatteryLatched,
  input wire logic lowBatterySampled,
  input wire rcs_state_t seqState
);
  logic [7:0] pktForce;
  logic [7:0] pktValue;
  logic isOverride;
  assign pktForce = pktData[PKT_B1_MSB:PKT_B1_LSB];
  assign pktValue = pktData[PKT_B0_MSB:PKT_B0_LSB];
  assign isOverride = pktValid && pktData[PKT_ID_MSB:PKT_ID_LSB] == ID_LINE_OVERRIDE;

  // Cycles already spent in the off state; a long step outgrows any delay range
  localparam int OFF_LIMIT = int'(STEP_MASK_OFF) * UNIT_CYCLES;
  logic [31:0] offCnt;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      offCnt <= 32'h00000000;
    end else if (seqState == RCS_OFF) begin
      offCnt <= offCnt + 32'h00000001;
    end else begin
      offCnt <= 32'h00000000;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // ==========================================================
  // Pin drive and override
  reset_float_a: assert property (disable iff (1'b0) !nrst |-> receiverControlOeN == 8'hFF)
    else $error("control lines driven during reset");
  drive_run_a: assert property (nrst |=> receiverControlOeN == 8'h00)
    else $error("control lines not driven after reset");
  force_line_a: assert property (isOverride |-> ##2 ((receiverControlLines ^ $past(pktValue, 2))
    & $past(pktForce, 2)) == 8'h00) else $error("forced line value wrong");

  // ==========================================================
  // Sequencing
  idle_wait_a: assert property (seqState == RCS_IDLE && !receiverOn |=> seqState == RCS_IDLE)
    else $error("left idle without turn-on");
  turn_on_a: assert property (seqState == RCS_IDLE && receiverOn |=> seqState == RCS_OFF)
    else $error("turn-on did not enter off state");
  off_hold_a: assert property ($rose(seqState == RCS_OFF) ##0 receiverOn [*4] |-> seqState == RCS_OFF)
    else $error("off state shorter than one unit");
  off_bound_a: assert property (seqState == RCS_OFF |-> offCnt < 32'(OFF_LIMIT))
    else $error("off state longer than longest step");
  sync_wait_a: assert property ($rose(seqState == RCS_SYNC) |-> !symbolsValid [*5])
    else $error("symbols valid before sync time");
  symbol_pass_a: assert property (symbolsValid |-> symbolHi == $past(externalSymbolInHi)
    && symbolLo == $past(externalSymbolInLo)) else $error("symbol not passed through");
  lowbat_take_a: assert property (lowBatterySampled |-> lowBatteryLatched == $past(lowBatteryInput))
    else $error("low battery value not taken");
endmodule

bind rcs_sequencer rcs_sequencer_chk #(.UNIT_CYCLES(UNIT_CYCLES)) rcs_sequencer_chk_i (.clk, .nrst,
  .pktValid, .pktData, .receiverOn, .lowBatteryInput, .externalSymbolInHi, .externalSymbolInLo,
  .receiverControlLines, .receiverControlOeN, .symbolsValid, .symbolHi, .symbolLo,
  .lowBatteryLatched, .lowBatterySampled, .seqState);

// file: tb/rcs_receiver_model.sv
/*
  Paging receiver model on the control lines: gives symbols and a battery level.
  Assumes the bench sets the battery level; symbols are never steady.
*/
`timescale 1ns/1ps

module rcs_receiver_model (
  input wire logic clk,
  input wire logic [7:0] controlLines,
  input wire logic [7:0] controlOeN,
  input wire logic lowBattery,
  output logic batteryLow,
  output logic symHi,
  output logic symLo
);
  logic [2:0] cnt = 3'h0;
  logic powered;
  assign powered = |(controlLines & ~controlOeN);
  assign batteryLow = lowBattery;
  initial {symHi, symLo} = 2'b00;
  // Unpowered outputs toggle so stale values never look valid
  always @(posedge clk) begin
    cnt <= cnt + 3'h1;
    {symHi, symLo} <= powered ? cnt[2:1] : ~{symHi, symLo};
  end
endmodule

// file: tb/receiver_control_sequencer_tb.sv
/*
  Bench of the receiver control sequencer: packet writes and level changes
  with expected line values. Assumes a step unit of 4 clock cycles.
*/
`timescale 1ns/1ps

module receiver_control_sequencer_tb import rcs_pkg::*;;
  localparam int UNIT = 4;
  logic clk = 1'b0;
  logic nrst = 1'b1;
  logic pktValid = 1'b0;
  logic [31:0] pktData = 32'h0;
  logic receiverOn = 1'b0;
  logic lowBatteryLevel = 1'b1;
  logic lowBatteryInput, externalSymbolInHi, externalSymbolInLo;
  logic [7:0] receiverControlLines, receiverControlOeN;
  logic symbolsValid, symbolHi, symbolLo, lowBatteryLatched, lowBatterySampled;
  rcs_state_t seqState;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;

  rcs_sequencer #(.UNIT_CYCLES(UNIT)) rcs_sequencer_i (.clk, .nrst, .pktValid, .pktData, .receiverOn,
    .lowBatteryInput, .externalSymbolInHi, .externalSymbolInLo, .receiverControlLines,
    .receiverControlOeN, .symbolsValid, .symbolHi, .symbolLo, .lowBatteryLatched,
    .lowBatterySampled, .seqState);
  rcs_receiver_model rcs_receiver_model_i (.clk, .controlLines(receiverControlLines),
    .controlOeN(receiverControlOeN), .lowBattery(lowBatteryLevel), .batteryLow(lowBatteryInput),
    .symHi(externalSymbolInHi), .symLo(externalSymbolInLo));

  initial begin
    forever #4 clk = ~clk;
  end

  // ==========================================================
  // Tasks
  task automatic summarize();
    if (err_total == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One idle cycle after each packet keeps the strobe a clean pulse
  task automatic send(input logic [7:0] id, input logic [7:0] b2, input logic [7:0] b1, input logic [7:0] b0);
    pktData = {id, b2, b1, b0};
    pktValid = 1'b1;
    @(posedge clk) #1;
    pktValid = 1'b0;
    @(posedge clk) #1;
  endtask

  // Waits for the lines to change; span 0 skips the duration check
  task automatic next_lines(input logic [7:0] exp, input int span);
    int n;
    logic [7:0] prev;
    n = 0;
    prev = receiverControlLines;
    while (receiverControlLines === prev && n < 3000) begin
      @(posedge clk) #1;
      n++;
    end
    check(receiverControlLines, exp);
    if (span > 0) check(n[7:0], span[7:0]);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      summarize();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    // A real falling edge, so the reset branch runs before the first clock edge
    #1 nrst = 1'b0;
    repeat (6) @(posedge clk);
    #1 check(receiverControlOeN, 8'hFF);
    nrst = 1'b1;
    @(posedge clk) #1;
    check(receiverControlOeN, 8'h00);
    check(receiverControlLines, RST_PATTERN);
    send(8'h10, 8'h08, 8'h11, 8'h02);
    send(8'h11, 8'h80, 8'h22, 8'h81);
    send(8'h12, 8'h80, 8'h33, 8'h03);
    send(8'h13, 8'h00, 8'h44, 8'h01);
    send(8'h14, 8'h80, 8'h55, 8'h01);
    send(8'h16, 8'h00, 8'h66, 8'h02);
    send(8'h1A, 8'h80, 8'h77, 8'h01);
    send(8'h1B, 8'h00, 8'h88, 8'h01);
    check(receiverControlLines, 8'h11);
    receiverOn = 1'b1;
    next_lines(8'h22, 0);
    check(lowBatteryLatched, 8'h01);
    next_lines(8'h33, UNIT);
    next_lines(8'h66, 3 * UNIT);
    repeat (10) @(posedge clk);
    #1 check(symbolsValid, 8'h01);
    send(ID_LINE_OVERRIDE, 8'h00, 8'h0F, 8'h05);
    check(receiverControlLines, 8'h65);
    send(8'h0E, 8'h00, 8'hFF, 8'hFF);
    check(receiverControlLines, 8'h65);
    send(ID_LINE_OVERRIDE, 8'h00, 8'h00, 8'hFF);
    check(receiverControlLines, 8'h66);
    receiverOn = 1'b0;
    next_lines(8'h77, 0);
    next_lines(8'h11, UNIT);
    check(seqState, RCS_IDLE);
    send(ID_LINE_OVERRIDE, 8'h00, 8'hF0, 8'hA0);
    check(receiverControlLines, 8'hA1);
    nrst = 1'b0;
    @(posedge clk) #1;
    check(receiverControlOeN, 8'hFF);
    nrst = 1'b1;
    @(posedge clk) #1;
    check(receiverControlLines, 8'h00);
    summarize();
  end
endmodule
